//--- core/scsc_status_top.v
// Channel command decode, summary status register and request outputs.
//
// Functional notes
// RULE1: Command 18H starts CRC on delay-register byte.
// RULE2: Host issues forced CRC after second CRC byte.
// RULE3: CRC status valid 15 clocks later, until next byte.
// RULE4: Command 21H resets channel, disables, flushes buffers.
// RULE5: Command 31H enters search, sets search flag.
// RULE6: Command 00H changes nothing.
// RULE7: Summary status cleared by reset, channel reset, stop.
// RULE8: Transmit summary ORs underrun, idle, CTS-change terms.
// RULE9: Transmit request when summary and its enable set.
// RULE10: Receive summary ORs enabled line, error, frame flags.
// RULE11: Frame-done term needs enable, end, last read.
// RULE12: Receive request when summary and its enable set.
// RULE13: Summary bits five to two read zero.
// RULE14: Transmit room hysteresis between low and high+1.
// RULE15: Transmit room zero when disabled or underrun.
// RULE16: Host writes transmit buffer only with room.
// RULE17: Transmit room drives DMA request and interrupt.
// RULE18: Word write at high 31 drops second byte.
// RULE19: Receive available sets at threshold+1 or end-of-message; the code sets on end-of-message in bit-sync mode only.
// RULE20: Receive available holds until buffer empty.
// RULE21: Receive available drives DMA request and interrupt.
// RULE22: Summary bits are unlatched combinational levels.
`include "scsc_consts.vh"

module scsc_status_top (
    input  wire                      i_clk,
    input  wire                      i_rst_n,
    input  wire [`SCSC_ADDR_W-1:0]   i_addr,
    input  wire [7:0]                i_wdata,
    input  wire                      i_wr,
    input  wire                      i_rd,
    output reg  [7:0]                o_rdata,
    input  wire                      i_sys_stop,
    input  wire [7:0]                i_line_event_status,
    input  wire [7:0]                i_receive_error_status,
    input  wire                      i_frame_ended,
    input  wire                      i_last_char_read,
    input  wire                      i_tx_enabled,
    input  wire                      i_underrun_event,
    input  wire [`SCSC_COUNT_W-1:0]  i_tx_count,
    input  wire [`SCSC_COUNT_W-1:0]  i_rx_count,
    input  wire                      i_bitsync_mode,
    input  wire                      i_eom_enter,
    input  wire                      i_rx_byte_loaded,
    input  wire [7:0]                i_rx_delay_byte,
    input  wire                      i_search_lock,
    input  wire                      i_host_word_write,
    input  wire                      i_dma_write,
    output wire                      o_tx_irq,
    output wire                      o_rx_irq,
    output wire                      o_tx_room_irq,
    output wire                      o_rx_avail_irq,
    output wire                      o_tx_dma_req,
    output wire                      o_rx_dma_req,
    output wire                      o_tx_room_flag,
    output wire                      o_rx_avail_flag,
    output wire                      o_drop_second_byte,
    output wire                      o_chan_reset,
    output wire                      o_search_enter,
    output wire                      o_crc_force,
    output wire [7:0]                o_crc_byte,
    output wire                      o_crc_status_valid
);

    // Software-held enables and thresholds.
    reg  [7:0]                summary_irq_enable;
    reg  [7:0]                line_event_irq_enable;
    reg  [7:0]                receive_error_irq_enable;
    reg  [7:0]                frame_end_irq_enable;
    reg  [`SCSC_THRESH_W-1:0] tx_low_level;
    reg  [`SCSC_THRESH_W-1:0] tx_high_level;
    reg  [`SCSC_THRESH_W-1:0] rx_level;
    reg                       search_active_flag;

    wire                      cmd_wr;
    wire                      chan_clear;
    wire                      tx_room_flag;
    wire                      rx_avail_flag;
    wire                      frame_done_read_flag;
    wire                      tx_irq_summary;
    wire                      rx_irq_summary;
    wire [7:0]                channel_summary_status;
    wire                      tx_summary_enable;
    wire                      rx_summary_enable;
    wire                      tx_room_irq_enable;
    wire                      rx_avail_irq_enable;
    reg  [7:0]                next_rdata;

    assign cmd_wr     = i_wr && (i_addr == `SCSC_OFF_COMMAND);
    assign chan_clear = o_chan_reset || i_sys_stop;

    scsc_cmd_decode u_cmd (
        .i_clk              (i_clk),
        .i_rst_n            (i_rst_n),
        .i_cmd_wr           (cmd_wr),
        .i_cmd              (i_wdata),
        .i_rx_delay_byte    (i_rx_delay_byte),
        .i_rx_byte_loaded   (i_rx_byte_loaded),
        .i_sys_stop         (i_sys_stop),
        .o_chan_reset       (o_chan_reset),
        .o_search_enter     (o_search_enter),
        .o_crc_force        (o_crc_force),
        .o_crc_byte         (o_crc_byte),
        .o_crc_status_valid (o_crc_status_valid)
    );

    scsc_ready_flags u_ready (
        .i_clk            (i_clk),
        .i_rst_n          (i_rst_n),
        .i_clear          (chan_clear),
        .i_tx_enabled     (i_tx_enabled),
        .i_underrun_event (i_underrun_event),
        .i_tx_count       (i_tx_count),
        .i_tx_low         (tx_low_level),
        .i_tx_high        (tx_high_level),
        .i_rx_count       (i_rx_count),
        .i_rx_thresh      (rx_level),
        .i_bitsync_mode   (i_bitsync_mode),
        .i_eom_enter      (i_eom_enter),
        .o_tx_room        (tx_room_flag),
        .o_rx_avail       (rx_avail_flag)
    );

    // Register writes; the channel reset pulse returns every enable and threshold register to its initial value.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            summary_irq_enable       <= `SCSC_REG_RESET;
            line_event_irq_enable    <= `SCSC_REG_RESET;
            receive_error_irq_enable <= `SCSC_REG_RESET;
            frame_end_irq_enable     <= `SCSC_REG_RESET;
            tx_low_level             <= {`SCSC_THRESH_W{1'b0}};
            tx_high_level            <= {`SCSC_THRESH_W{1'b0}};
            rx_level                 <= {`SCSC_THRESH_W{1'b0}};
        end else if (o_chan_reset) begin
            summary_irq_enable       <= `SCSC_REG_RESET; // RULE4
            line_event_irq_enable    <= `SCSC_REG_RESET; // RULE4
            receive_error_irq_enable <= `SCSC_REG_RESET; // RULE4
            frame_end_irq_enable     <= `SCSC_REG_RESET; // RULE4
            tx_low_level             <= {`SCSC_THRESH_W{1'b0}}; // RULE4
            tx_high_level            <= {`SCSC_THRESH_W{1'b0}}; // RULE4
            rx_level                 <= {`SCSC_THRESH_W{1'b0}}; // RULE4
        end else if (i_wr) begin
            case (i_addr)
                `SCSC_OFF_SUMMARY_EN: begin
                    summary_irq_enable <= i_wdata;
                end
                `SCSC_OFF_LINE_EN: begin
                    line_event_irq_enable <= i_wdata;
                end
                `SCSC_OFF_RXERR_EN: begin
                    receive_error_irq_enable <= i_wdata;
                end
                `SCSC_OFF_FRAME_EN: begin
                    frame_end_irq_enable <= i_wdata;
                end
                `SCSC_OFF_TX_LOW: begin
                    tx_low_level <= i_wdata[`SCSC_THRESH_W-1:0];
                end
                `SCSC_OFF_TX_HIGH: begin
                    tx_high_level <= i_wdata[`SCSC_THRESH_W-1:0];
                end
                `SCSC_OFF_RX_THRESH: begin
                    rx_level <= i_wdata[`SCSC_THRESH_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Search flag is set by the command and dropped when the recovery unit locks.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            search_active_flag <= 1'b0;
        end else if (o_search_enter) begin
            search_active_flag <= 1'b1; // RULE5
        end else if (chan_clear || i_search_lock) begin
            search_active_flag <= 1'b0;
        end
    end

    // Summary bits follow their flags and enables directly, with no latch of their own.
    assign frame_done_read_flag = frame_end_irq_enable[`SCSC_BIT_FRAME_DONE] &&
                                  i_frame_ended && i_last_char_read; // RULE11

    assign tx_irq_summary = !chan_clear &&
        (|(i_line_event_status & line_event_irq_enable & `SCSC_TX_LINE_MASK)); // RULE8 RULE22

    assign rx_irq_summary = !chan_clear &&
        ((|(i_line_event_status & line_event_irq_enable & `SCSC_RX_LINE_MASK)) ||
         (|(i_receive_error_status & receive_error_irq_enable & `SCSC_RX_ERR_MASK)) ||
         frame_done_read_flag); // RULE10 RULE22 RULE7

    assign channel_summary_status = {tx_irq_summary, rx_irq_summary, 4'h0,
                                     tx_room_flag, rx_avail_flag}; // RULE13

    assign tx_summary_enable   = summary_irq_enable[`SCSC_BIT_TX_SUMMARY];
    assign rx_summary_enable   = summary_irq_enable[`SCSC_BIT_RX_SUMMARY];
    assign tx_room_irq_enable  = summary_irq_enable[`SCSC_BIT_TX_ROOM];
    assign rx_avail_irq_enable = summary_irq_enable[`SCSC_BIT_RX_AVAIL];

    assign o_tx_irq       = tx_irq_summary && tx_summary_enable; // RULE9
    assign o_rx_irq       = rx_irq_summary && rx_summary_enable; // RULE12
    assign o_tx_room_irq  = tx_room_flag && tx_room_irq_enable; // RULE17
    assign o_rx_avail_irq = rx_avail_flag && rx_avail_irq_enable; // RULE21
    assign o_tx_dma_req   = tx_room_flag; // RULE17
    assign o_rx_dma_req   = rx_avail_flag; // RULE21
    assign o_tx_room_flag  = tx_room_flag;
    assign o_rx_avail_flag = rx_avail_flag;

    // A host word write with the high threshold at full loses its upper byte; DMA never does.
    assign o_drop_second_byte = i_host_word_write && !i_dma_write &&
                                (tx_high_level == `SCSC_FULL_HIGH); // RULE18

    always @* begin
        case (i_addr)
            `SCSC_OFF_SUMMARY:    next_rdata = channel_summary_status;
            `SCSC_OFF_SUMMARY_EN: next_rdata = summary_irq_enable;
            `SCSC_OFF_LINE_EN:    next_rdata = line_event_irq_enable;
            `SCSC_OFF_RXERR_EN:   next_rdata = receive_error_irq_enable;
            `SCSC_OFF_FRAME_EN:   next_rdata = frame_end_irq_enable;
            `SCSC_OFF_TX_LOW:     next_rdata = {3'h0, tx_low_level};
            `SCSC_OFF_TX_HIGH:    next_rdata = {3'h0, tx_high_level};
            `SCSC_OFF_RX_THRESH:  next_rdata = {3'h0, rx_level};
            `SCSC_OFF_SEARCH:     next_rdata = {7'h00, search_active_flag};
            default:              next_rdata = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? next_rdata : 8'h00;
        end
    end

endmodule

//--- core/scsc_consts.vh
// Register offsets, field positions, command codes and timing counts of the channel status block.
`ifndef SCSC_CONSTS_VH
`define SCSC_CONSTS_VH

`define SCSC_ADDR_W           4
`define SCSC_OFF_COMMAND      4'h0
`define SCSC_OFF_SUMMARY      4'h1
`define SCSC_OFF_SUMMARY_EN   4'h2
`define SCSC_OFF_LINE_EN      4'h3
`define SCSC_OFF_RXERR_EN     4'h4
`define SCSC_OFF_FRAME_EN     4'h5
`define SCSC_OFF_TX_LOW       4'h6
`define SCSC_OFF_TX_HIGH      4'h7
`define SCSC_OFF_RX_THRESH    4'h8
`define SCSC_OFF_SEARCH       4'h9

`define SCSC_CMD_NOP          8'h00
`define SCSC_CMD_FORCE_CRC    8'h18
`define SCSC_CMD_CHAN_RESET   8'h21
`define SCSC_CMD_SEARCH       8'h31

`define SCSC_BIT_TX_SUMMARY   7
`define SCSC_BIT_RX_SUMMARY   6
`define SCSC_BIT_TX_ROOM      1
`define SCSC_BIT_RX_AVAIL     0
`define SCSC_BIT_FRAME_DONE   7

`define SCSC_TX_LINE_MASK     8'hC8
`define SCSC_RX_LINE_MASK     8'h37
`define SCSC_RX_ERR_MASK      8'hFC

`define SCSC_REG_RESET        8'h00
`define SCSC_THRESH_W         5
`define SCSC_COUNT_W          6
`define SCSC_FULL_HIGH        5'h1F

`define SCSC_CRC_VALID_CYC    4'hF
`define SCSC_CRC_CNT_W        4

`endif

//--- core/scsc_cmd_decode.v
// Command decoder for no-op, forced receive CRC, channel reset and search entry.
`include "scsc_consts.vh"

module scsc_cmd_decode (
    input  wire       i_clk,
    input  wire       i_rst_n,
    input  wire       i_cmd_wr,
    input  wire [7:0] i_cmd,
    input  wire [7:0] i_rx_delay_byte,
    input  wire       i_rx_byte_loaded,
    input  wire       i_sys_stop,
    output reg        o_chan_reset,
    output reg        o_search_enter,
    output reg        o_crc_force,
    output reg  [7:0] o_crc_byte,
    output reg        o_crc_status_valid
);

    reg [`SCSC_CRC_CNT_W-1:0] crc_wait;
    reg                       crc_busy;

    wire hit_crc    = i_cmd_wr && (i_cmd == `SCSC_CMD_FORCE_CRC);
    wire hit_reset  = i_cmd_wr && (i_cmd == `SCSC_CMD_CHAN_RESET);
    wire hit_search = i_cmd_wr && (i_cmd == `SCSC_CMD_SEARCH);

    // Command 00H and all unlisted codes leave every output untouched.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_chan_reset   <= 1'b0;
            o_search_enter <= 1'b0;
            o_crc_force    <= 1'b0;
            o_crc_byte     <= 8'h00;
        end else begin
            o_chan_reset   <= hit_reset; // RULE4
            o_search_enter <= hit_search; // RULE5
            o_crc_force    <= hit_crc; // RULE1 RULE6
            if (hit_crc) begin
                o_crc_byte <= i_rx_delay_byte; // RULE1
            end
        end
    end

    // The CRC result is declared valid a fixed number of clocks after the command.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crc_wait           <= {`SCSC_CRC_CNT_W{1'b0}};
            crc_busy           <= 1'b0;
            o_crc_status_valid <= 1'b0;
        end else if (hit_reset || i_sys_stop) begin
            crc_wait           <= {`SCSC_CRC_CNT_W{1'b0}};
            crc_busy           <= 1'b0;
            o_crc_status_valid <= 1'b0;
        end else if (hit_crc) begin
            crc_wait           <= `SCSC_CRC_CNT_W'd1;
            crc_busy           <= 1'b1;
            o_crc_status_valid <= 1'b0;
        end else if (crc_busy) begin
            if (crc_wait == `SCSC_CRC_VALID_CYC - 4'h1) begin
                crc_busy           <= 1'b0;
                o_crc_status_valid <= 1'b1; // RULE3
            end else begin
                crc_wait <= crc_wait + `SCSC_CRC_CNT_W'd1;
            end
        end else if (i_rx_byte_loaded) begin
            o_crc_status_valid <= 1'b0; // RULE3
        end
    end

endmodule

//--- core/scsc_ready_flags.v
// Transmit-room and receive-available flags with threshold hysteresis.
`include "scsc_consts.vh"

module scsc_ready_flags (
    input  wire                     i_clk,
    input  wire                     i_rst_n,
    input  wire                     i_clear,
    input  wire                     i_tx_enabled,
    input  wire                     i_underrun_event,
    input  wire [`SCSC_COUNT_W-1:0] i_tx_count,
    input  wire [`SCSC_THRESH_W-1:0] i_tx_low,
    input  wire [`SCSC_THRESH_W-1:0] i_tx_high,
    input  wire [`SCSC_COUNT_W-1:0] i_rx_count,
    input  wire [`SCSC_THRESH_W-1:0] i_rx_thresh,
    input  wire                     i_bitsync_mode,
    input  wire                     i_eom_enter,
    output reg                      o_tx_room,
    output reg                      o_rx_avail
);

    wire [`SCSC_COUNT_W-1:0] tx_low_ext  = {1'b0, i_tx_low};
    wire [`SCSC_COUNT_W-1:0] tx_high_one = {1'b0, i_tx_high} + `SCSC_COUNT_W'd1;
    wire [`SCSC_COUNT_W-1:0] rx_th_one   = {1'b0, i_rx_thresh} + `SCSC_COUNT_W'd1;
    reg                      next_tx_room;
    reg                      next_rx_avail;

    always @* begin
        next_tx_room = o_tx_room;
        if (!i_tx_enabled || i_underrun_event) begin
            next_tx_room = 1'b0; // RULE15
        end else if (i_tx_count <= tx_low_ext) begin
            next_tx_room = 1'b1; // RULE14
        end else if (i_tx_count >= tx_high_one) begin
            next_tx_room = 1'b0; // RULE14
        end
    end

    // Setting wins over emptiness so an end-of-message byte entering in bit-sync mode is not lost to an empty count; a channel clear in the same cycle still wins.
    always @* begin
        next_rx_avail = o_rx_avail;
        if ((i_rx_count >= rx_th_one) || (i_bitsync_mode && i_eom_enter)) begin
            next_rx_avail = 1'b1; // RULE19
        end else if (i_rx_count == {`SCSC_COUNT_W{1'b0}}) begin
            next_rx_avail = 1'b0; // RULE20
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_room  <= 1'b0;
            o_rx_avail <= 1'b0;
        end else if (i_clear) begin
            o_tx_room  <= 1'b0; // RULE7
            o_rx_avail <= 1'b0; // RULE7
        end else begin
            o_tx_room  <= next_tx_room;
            o_rx_avail <= next_rx_avail;
        end
    end

endmodule

//--- tb/scsc_status_assertions.sv
// Port-level assertions for the channel status block.
module scsc_status_chk (
    input wire       i_clk,
    input wire       i_rst_n,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] o_rdata,
    input wire       i_sys_stop,
    input wire [7:0] i_line_event_status,
    input wire [7:0] i_receive_error_status,
    input wire       i_frame_ended,
    input wire       i_last_char_read,
    input wire       i_tx_enabled,
    input wire       i_underrun_event,
    input wire [5:0] i_rx_count,
    input wire [7:0] i_rx_delay_byte,
    input wire       o_tx_irq,
    input wire       o_rx_irq,
    input wire       o_tx_room_irq,
    input wire       o_tx_dma_req,
    input wire       o_rx_dma_req,
    input wire       o_tx_room_flag,
    input wire       o_rx_avail_flag,
    input wire       o_chan_reset,
    input wire       o_crc_force,
    input wire [7:0] o_crc_byte,
    input wire       o_crc_status_valid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire cmd_wr = i_wr && i_addr == 4'h0;
    a_crc_start: assert property (
        cmd_wr && i_wdata == 8'h18 |=> o_crc_force && o_crc_byte == $past(i_rx_delay_byte))
        else $error("crc start");
    a_crc_valid_time: assert property (
        cmd_wr && i_wdata == 8'h18 |-> ##15 o_crc_status_valid)
        else $error("crc valid");
    a_chan_reset_pulse: assert property (
        cmd_wr && i_wdata == 8'h21 |=> o_chan_reset ##1 !o_chan_reset)
        else $error("reset pulse");
    a_stop_clears: assert property (
        i_sys_stop ##1 i_sys_stop |-> !o_tx_irq && !o_rx_irq)
        else $error("stop clear");
    a_tx_irq_cause: assert property (
        o_tx_irq |-> (i_line_event_status & 8'hC8) != 8'h00)
        else $error("tx cause");
    a_rx_irq_cause: assert property (
        o_rx_irq |-> (i_line_event_status & 8'h37) != 8'h00
            || (i_receive_error_status & 8'hFC) != 8'h00 || (i_frame_ended && i_last_char_read))
        else $error("rx cause");
    a_dma_mirror: assert property (
        o_tx_dma_req == o_tx_room_flag && o_rx_dma_req == o_rx_avail_flag
            && (!o_tx_room_irq || o_tx_room_flag))
        else $error("dma mirror");
    a_room_forced_off: assert property (
        !i_tx_enabled || i_underrun_event |=> !o_tx_room_flag)
        else $error("room off");
    a_avail_holds: assert property (
        o_rx_avail_flag && i_rx_count != 6'h00 && !i_sys_stop && !o_chan_reset |=> o_rx_avail_flag)
        else $error("avail hold");
    a_reserved_zero: assert property (
        i_rd && i_addr == 4'h1 |=> o_rdata[5:2] == 4'h0)
        else $error("reserved bits");
endmodule

bind scsc_status_top scsc_status_chk i_scsc_status_chk (.*);

//--- tb/scsc_host_model.sv
// Host side model: register bus master and transmit buffer writer.
module scsc_host_model (
    input  wire        i_clk,
    input  wire  [7:0] i_rdata,
    input  wire        i_tx_room_flag,
    output logic [3:0] o_addr,
    output logic [7:0] o_wdata,
    output logic       o_wr,
    output logic       o_rd,
    output logic [5:0] o_tx_count
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_addr = 4'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_tx_count = 6'h00;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
    task automatic tx_fill(output int n);
        n = 0;
        repeat (40) begin
            @(posedge i_clk);
            @(posedge i_clk);
            #1;
            if (i_tx_room_flag === 1'b1) begin
                @(posedge i_clk);
                o_tx_count <= o_tx_count + 6'h01;
                n++;
            end
        end
    endtask
    task automatic tx_set(input logic [5:0] v);
        @(posedge i_clk);
        o_tx_count <= v;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
endmodule

//--- tb/tb_scsc_status_top.sv
// Self-checking bench for the channel status block.
module tb_scsc_status_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_clk = 0, i_rst_n = 0, i_sys_stop = 0, i_frame_ended = 0, i_last_char_read = 0;
    logic       i_tx_enabled = 0, i_underrun_event = 0, i_bitsync_mode = 0, i_eom_enter = 0;
    logic       i_rx_byte_loaded = 0, i_search_lock = 0, i_host_word_write = 0, i_dma_write = 0;
    logic       i_wr, i_rd, o_tx_irq, o_rx_irq, o_tx_room_irq, o_rx_avail_irq, o_tx_dma_req;
    logic       o_rx_dma_req, o_tx_room_flag, o_rx_avail_flag, o_drop_second_byte, o_chan_reset;
    logic       o_search_enter, o_crc_force, o_crc_status_valid;
    logic [3:0] i_addr;
    logic [5:0] i_tx_count, i_rx_count = 0;
    logic [7:0] i_wdata, o_rdata, o_crc_byte, rd, ex, i_line_event_status = 0;
    logic [7:0] i_receive_error_status = 0, i_rx_delay_byte = 8'hA5;
    logic [7:0] txm = 8'hC8, rxm = 8'h37, erm = 8'hFC;
    int         failures = 0, compares = 0, cycles = 0, n;
    scsc_status_top i_scsc_status_top (.*);
    scsc_host_model host (.i_clk, .i_rdata(o_rdata), .i_tx_room_flag(o_tx_room_flag),
        .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd), .o_tx_count(i_tx_count));
    always #12.5 i_clk = ~i_clk;
    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
        host.rd_reg(a, rd);
        chk(what, rd, exp);
    endtask
    task automatic rx_set(input logic [5:0] v);
        @(posedge i_clk) i_rx_count <= v;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int a = 1; a <= 9; a++) rchk(a[3:0], 8'h00, "reset value");
        rchk(4'hF, 8'h00, "unmapped");
        host.wr_reg(4'h3, 8'hFF);
        host.wr_reg(4'h4, 8'hFF);
        host.wr_reg(4'h2, 8'hC3);
        for (int b = 0; b < 16; b++) begin
            @(posedge i_clk) begin
                i_line_event_status <= (b < 8) ? 8'h01 << b : 8'h00;
                i_receive_error_status <= (b < 8) ? 8'h00 : 8'h01 << (b - 8);
            end
            ex = (b < 8) ? {txm[b], rxm[b], 6'h00} : {1'b0, erm[b - 8], 6'h00};
            rchk(4'h1, ex, "summary bit");
            chk("tx irq", o_tx_irq, ex[7]);
            chk("rx irq", o_rx_irq, ex[6]);
        end
        @(posedge i_clk) {i_line_event_status, i_receive_error_status} <= 16'hFFFF;
        rchk(4'h1, 8'hC0, "all sources");
        host.wr_reg(4'h2, 8'h00);
        chk("masked irqs", {o_tx_irq, o_rx_irq}, 8'h00);
        @(posedge i_clk) {i_line_event_status, i_receive_error_status} <= 16'h0000;
        rchk(4'h1, 8'h00, "sources gone");
        host.wr_reg(4'h2, 8'hC3);
        host.wr_reg(4'h5, 8'h80);
        @(posedge i_clk) i_frame_ended <= 1'b1;
        rchk(4'h1, 8'h00, "frame end unread");
        @(posedge i_clk) i_last_char_read <= 1'b1;
        rchk(4'h1, 8'h40, "frame done read");
        @(posedge i_clk) i_sys_stop <= 1'b1;
        rchk(4'h1, 8'h00, "stop clears");
        chk("stop irq", o_rx_irq, 8'h00);
        @(posedge i_clk) {i_sys_stop, i_frame_ended} <= 2'b00;
        repeat (2) begin
            @(posedge i_clk) i_rx_byte_loaded <= 1'b1;
            @(posedge i_clk) i_rx_byte_loaded <= 1'b0;
        end
        host.wr_reg(4'h0, 8'h18);
        chk("crc force", {o_crc_force, o_crc_byte}, {1'b1, 8'hA5});
        repeat (13) @(posedge i_clk);
        #1 chk("crc early", o_crc_status_valid, 8'h00);
        @(posedge i_clk);
        #1 chk("crc valid", o_crc_status_valid, 8'h01);
        @(posedge i_clk) i_rx_byte_loaded <= 1'b1;
        @(posedge i_clk) i_rx_byte_loaded <= 1'b0;
        #1 chk("crc ended", o_crc_status_valid, 8'h00);
        host.wr_reg(4'h0, 8'h31);
        chk("search pulse", o_search_enter, 8'h01);
        rchk(4'h9, 8'h01, "search flag");
        @(posedge i_clk) i_search_lock <= 1'b1;
        @(posedge i_clk) i_search_lock <= 1'b0;
        host.wr_reg(4'h0, 8'h00);
        chk("nop", {o_chan_reset, o_search_enter, o_crc_force}, 8'h00);
        rchk(4'h3, 8'hFF, "nop keeps");
        host.wr_reg(4'h6, 8'h02);
        host.wr_reg(4'h7, 8'h05);
        host.wr_reg(4'h2, 8'h03);
        @(posedge i_clk) i_tx_enabled <= 1'b1;
        host.tx_fill(n);
        chk("filled", n[7:0], 8'h06);
        host.tx_set(6'h04);
        chk("room hold off", o_tx_room_flag, 8'h00);
        host.tx_set(6'h02);
        chk("room on", {o_tx_room_flag, o_tx_dma_req, o_tx_room_irq}, 8'h07);
        rchk(4'h1, 8'h02, "room summary");
        host.tx_set(6'h04);
        chk("room hold on", o_tx_room_flag, 8'h01);
        @(posedge i_clk) i_underrun_event <= 1'b1;
        @(posedge i_clk) i_underrun_event <= 1'b0;
        #1 chk("underrun", o_tx_room_flag, 8'h00);
        host.tx_set(6'h02);
        @(posedge i_clk) i_tx_enabled <= 1'b0;
        @(posedge i_clk);
        #1 chk("disabled", o_tx_room_flag, 8'h00);
        @(posedge i_clk) i_tx_enabled <= 1'b1;
        host.wr_reg(4'h7, 8'h1F);
        host.tx_set(6'h1F);
        chk("room at 31", o_tx_room_flag, 8'h01);
        @(posedge i_clk) i_host_word_write <= 1'b1;
        #1 chk("drop word", o_drop_second_byte, 8'h01);
        @(posedge i_clk) i_dma_write <= 1'b1;
        #1 chk("dma no drop", o_drop_second_byte, 8'h00);
        @(posedge i_clk) i_dma_write <= 1'b0;
        host.wr_reg(4'h7, 8'h1E);
        chk("high 30 no drop", o_drop_second_byte, 8'h00);
        @(posedge i_clk) i_host_word_write <= 1'b0;
        host.wr_reg(4'h8, 8'h03);
        rx_set(6'h03);
        chk("avail below", o_rx_avail_flag, 8'h00);
        rx_set(6'h04);
        chk("avail on", {o_rx_avail_flag, o_rx_dma_req, o_rx_avail_irq}, 8'h07);
        rx_set(6'h01);
        chk("avail hold", o_rx_avail_flag, 8'h01);
        rx_set(6'h00);
        chk("avail empty", o_rx_avail_flag, 8'h00);
        rx_set(6'h01);
        @(posedge i_clk) i_eom_enter <= 1'b1;
        @(posedge i_clk) i_eom_enter <= 1'b0;
        #1 chk("eom byte sync", o_rx_avail_flag, 8'h00);
        @(posedge i_clk) {i_bitsync_mode, i_eom_enter} <= 2'b11;
        @(posedge i_clk) i_eom_enter <= 1'b0;
        #1 chk("eom bit sync", o_rx_avail_flag, 8'h01);
        rx_set(6'h00);
        host.wr_reg(4'h0, 8'h21);
        chk("chan reset", o_chan_reset, 8'h01);
        rchk(4'h3, 8'h00, "enables cleared");
        rchk(4'h7, 8'h00, "threshold cleared");
        rchk(4'h1, 8'h00, "summary cleared");
        final_report();
    end
endmodule
